//--- logic/swm_consts.svh
// Constants of the single-wire bus master: timing in ns, derived cycle counts, ROM command bytes.
// Assumes a 125 MHz clock; included by the master design file.
`ifndef SWM_CONSTS_SVH
`define SWM_CONSTS_SVH

`define SWM_CLK_NS              8
// Least times round up to whole cycles.
`define SWM_CYC(ns)             (((ns) + `SWM_CLK_NS - 1) / `SWM_CLK_NS)

`define SWM_POWERUP_WAIT_NS     1200000
// Standard speed.
`define SWM_STD_RST_LOW_NS      500000
`define SWM_STD_RST_HIGH_NS     480000
`define SWM_STD_PRES_SAMPLE_NS  70000
`define SWM_STD_SLOT_NS         70000
`define SWM_STD_ZERO_LOW_NS     65000
`define SWM_STD_ONE_LOW_NS      6000
`define SWM_STD_READ_SAMPLE_NS  13000
`define SWM_STD_RECOVERY_NS     5000
// Overdrive speed.
`define SWM_FAST_RST_LOW_NS     70000
`define SWM_FAST_RST_HIGH_NS    48000
`define SWM_FAST_PRES_SAMPLE_NS 9000
`define SWM_FAST_SLOT_NS        11000
`define SWM_FAST_ZERO_LOW_NS    10000
`define SWM_FAST_ONE_LOW_NS     1000
`define SWM_FAST_READ_SAMPLE_NS 1750
`define SWM_FAST_RECOVERY_NS    2000

`define SWM_ROM_READ            8'h33
`define SWM_ROM_SEARCH          8'hF0
`define SWM_ROM_OVERDRIVE       8'h3C

`define SWM_RSP_WIDTH           8
`define SWM_RSP_DEPTH           16

`endif

//--- logic/swm_master.sv
// Bus master for a single-wire open-drain identity bus, with a response FIFO.
// Assumes an external pull-up on the line and a testbench that resolves the wire from lineOe.
`timescale 1ns/1ps
`include "swm_consts.svh"

module swm_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             clock,     // System clock.
	input  wire logic             reset,     // Synchronous reset.
	input  wire logic             inValid,   // Write request.
	output logic                  inReady,   // Room for a word.
	input  wire logic [WIDTH-1:0] inData,    // Word written.
	output logic                  outValid,  // Word available.
	input  wire logic             outReady,  // Reader takes the word.
	output logic [WIDTH-1:0]      outData    // Oldest word.
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wrPtr;
	logic [AW:0]      rdPtr;

	wire full  = (wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
	wire empty = (wrPtr == rdPtr);
	wire push  = inValid && !full;
	wire pop   = outReady && !empty;

	assign inReady  = !full;
	assign outValid = !empty;
	assign outData  = mem[rdPtr[AW-1:0]];

	always_ff @(posedge clock) begin
		if (push) begin
			mem[wrPtr[AW-1:0]] <= inData;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			wrPtr <= '0;
			rdPtr <= '0;
		end else begin
			wrPtr <= wrPtr + (AW+1)'(push);
			rdPtr <= rdPtr + (AW+1)'(pop);
		end
	end

	fifo_no_overfill_a: assert property (@(posedge clock) disable iff (reset)
		full |=> (wrPtr == $past(wrPtr)))
		else $error("FIFO pointer moved while full");

endmodule // swm_fifo

// How it works
// R1: Bits go and come least significant first.
// R2: Wait power-up delay before first bus activity.
// R3: Only this master starts any bus operation.
// R4: Line is only pulled low, never driven high.
// R5: Line is left released while idle.
// R6: Device tells slots from resets by length.
// R7: Slot timing keeps bit rate within limits.
// R8: Reset, then ROM command, then data read.
// R9: Reset pulse answered by device presence pulse.
// R10: ROM commands only after presence was seen.
// R11: Each slot lasts at least the slot minimum.
// R12: Reset low time within speed's reset window.
// R13: Device waits briefly before pulling presence.
// R14: Device holds presence low for bounded span.
// R15: Presence sampled inside presence sample window.
// R16: Zero write holds line low long enough.
// R17: One write releases line after short low.
// R18: Read slot short low, sample before limit.
// R19: Overdrive command speeds up; long reset slows.
// R20: Read-ROM returns family, serial, then CRC.
// R21: Search sends bit, complement, reads choice.
// R22: Device holds line low to return zero.
// R23: Device samples written bit mid slot.
// R24: Slots wait for reset; reset restarts commands.
module swm_master
	import swm_pkg::*;
#(
	parameter int POWERUP_CYC   = `SWM_CYC(`SWM_POWERUP_WAIT_NS),
	parameter int STD_RLOW_CYC  = `SWM_CYC(`SWM_STD_RST_LOW_NS),
	parameter int STD_RHIGH_CYC = `SWM_CYC(`SWM_STD_RST_HIGH_NS),
	parameter int STD_PRES_CYC  = `SWM_CYC(`SWM_STD_PRES_SAMPLE_NS),
	parameter int STD_SLOT_CYC  = `SWM_CYC(`SWM_STD_SLOT_NS),
	parameter int STD_ZERO_CYC  = `SWM_CYC(`SWM_STD_ZERO_LOW_NS)
) (
	input  wire logic       clock,      // 125 MHz system clock.
	input  wire logic       reset,      // Synchronous reset, active high.
	input  wire logic       cmdValid,   // Command offered.
	output logic            cmdReady,   // Command taken this cycle.
	input  wire logic [2:0] cmdOp,      // Command code.
	input  wire logic [7:0] cmdData,    // Byte to write, or search direction in bit 0.
	output logic            cmdRefused, // Data command dropped, no presence yet.
	output logic            rspValid,   // Response byte available.
	input  wire logic       rspReady,   // Response byte taken.
	output logic [7:0]      rspData,    // Response byte.
	output logic            fastSpeed,  // Overdrive timing in use.
	output logic            linkUp,     // Presence seen since last reset.
	output logic            busy,       // Engine not idle.
	input  wire logic       lineIn,     // Data line level.
	output logic            lineOut,    // Data line drive value, always low.
	output logic            lineOe      // Pulls the data line low when high.
);
	localparam int CW = 18;

	function automatic logic [CW-1:0] pick(input logic f, input int s, input int o);
		return f ? CW'(o) : CW'(s);
	endfunction

	swm_state_t   state;
	swm_state_t   next_state;
	swm_op_t      op;
	logic [CW-1:0] cnt;
	logic [7:0]   shiftReg;
	logic [7:0]   cmdByte;
	logic [1:0]   bitCnt;
	logic [2:0]   byteBit;
	logic         sample;
	logic         presence;
	logic         afterReset;
	logic         tripTrue;
	logic         tripCmp;
	logic         dirBit;
	logic         stdReset;
	logic [7:0]   pushData;
	logic         fifoInReady;

	// Timing of the current speed.
	wire [CW-1:0] rLowCyc  = pick(fastSpeed, STD_RLOW_CYC, `SWM_CYC(`SWM_FAST_RST_LOW_NS));  // see R12
	wire [CW-1:0] rHighCyc = pick(fastSpeed, STD_RHIGH_CYC, `SWM_CYC(`SWM_FAST_RST_HIGH_NS));
	wire [CW-1:0] presCyc  = pick(fastSpeed, STD_PRES_CYC, `SWM_CYC(`SWM_FAST_PRES_SAMPLE_NS)); // see R15
	wire [CW-1:0] slotCyc  = pick(fastSpeed, STD_SLOT_CYC, `SWM_CYC(`SWM_FAST_SLOT_NS));     // see R7, R11
	wire [CW-1:0] recCyc   = pick(fastSpeed, `SWM_CYC(`SWM_STD_RECOVERY_NS), `SWM_CYC(`SWM_FAST_RECOVERY_NS));
	wire [CW-1:0] zeroCyc  = pick(fastSpeed, STD_ZERO_CYC, `SWM_CYC(`SWM_FAST_ZERO_LOW_NS)); // see R16
	wire [CW-1:0] oneCyc   = pick(fastSpeed, `SWM_CYC(`SWM_STD_ONE_LOW_NS), `SWM_CYC(`SWM_FAST_ONE_LOW_NS));
	wire [CW-1:0] rdSmpCyc = pick(fastSpeed, `SWM_CYC(`SWM_STD_READ_SAMPLE_NS), `SWM_CYC(`SWM_FAST_READ_SAMPLE_NS));

	wire isTrip     = (op == SWM_OP_TRIPLET);
	// Read slots and triplet reads send a one; the third triplet slot sends the chosen direction.
	wire slotBit    = isTrip ? ((bitCnt == 2'd2) ? dirBit : 1'b1) : shiftReg[0];          // see R1
	wire [CW-1:0] lowCyc = slotBit ? oneCyc : zeroCyc;                                   // see R17
	wire takeCmd    = cmdValid && (state == SWM_ST_IDLE);                                // see R3
	wire isResetOp  = (cmdOp == SWM_OP_RESET) || (cmdOp == SWM_OP_RESET_STD);
	wire refuse     = takeCmd && !isResetOp && !linkUp;                                  // see R10
	wire byteDone   = (byteBit == 3'd7);
	wire tripDone   = (bitCnt == 2'd2);
	wire chooseDir  = (tripTrue != sample) ? tripTrue : cmdByte[0];                      // see R21

	assign cmdReady   = (state == SWM_ST_IDLE);
	assign cmdRefused = refuse;
	assign busy       = (state != SWM_ST_IDLE);
	assign lineOut    = 1'b0;                                                            // see R4

	always_comb begin
		next_state = state;
		case (state)
			SWM_ST_PWRUP: if (cnt == CW'(POWERUP_CYC - 1)) next_state = SWM_ST_IDLE;   // see R2
			SWM_ST_IDLE: begin
				if (takeCmd && isResetOp) begin
					next_state = SWM_ST_RLOW;
				end else if (takeCmd && !refuse) begin
					next_state = SWM_ST_SLOW;
				end
			end
			SWM_ST_RLOW:  if (cnt == rLowCyc - 1'b1) next_state = SWM_ST_RHIGH;
			SWM_ST_RHIGH: if (cnt == rHighCyc - 1'b1) next_state = SWM_ST_PUSH;
			SWM_ST_SLOW:  if (cnt == lowCyc - 1'b1) next_state = SWM_ST_SHIGH;
			SWM_ST_SHIGH: if (cnt == slotCyc + recCyc - 1'b1) next_state = SWM_ST_NEXT;
			SWM_ST_NEXT: begin
				if (isTrip) begin
					next_state = tripDone ? SWM_ST_PUSH : SWM_ST_SLOW;
				end else if (!byteDone) begin
					next_state = SWM_ST_SLOW;
				end else begin
					next_state = (op == SWM_OP_READ) ? SWM_ST_PUSH : SWM_ST_IDLE;
				end
			end
			SWM_ST_PUSH:  if (fifoInReady) next_state = SWM_ST_IDLE;
			default:      next_state = SWM_ST_IDLE;
		endcase
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			state <= SWM_ST_PWRUP;
			cnt   <= '0;
		end else begin
			state <= next_state;
			cnt   <= (next_state != state) ? '0 : cnt + 1'b1;
		end
	end

	// The line is pulled only during reset low and slot low; elsewhere it is released.
	always_ff @(posedge clock) begin
		if (reset) begin
			lineOe <= 1'b0;
		end else begin
			lineOe <= (next_state == SWM_ST_RLOW) || (next_state == SWM_ST_SLOW);         // see R5
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			op       <= SWM_OP_RESET;
			cmdByte  <= 8'h00;
			stdReset <= 1'b0;
		end else if (takeCmd) begin
			op       <= swm_op_t'(cmdOp);
			cmdByte  <= cmdData;
			stdReset <= (cmdOp == SWM_OP_RESET_STD);
		end
	end

	// Bit sampling on the line: presence at its sample point, data at the read sample point.
	// Read slots always open with the short low, so the data sample counts from the slot's falling edge.
	always_ff @(posedge clock) begin
		if (reset) begin
			presence <= 1'b0;
			sample   <= 1'b1;
		end else if (state == SWM_ST_RHIGH && cnt == presCyc) begin
			presence <= !lineIn;                                                         // see R9
		end else if (state == SWM_ST_SHIGH && cnt == rdSmpCyc - oneCyc) begin
			sample   <= lineIn;                                                          // see R18
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			shiftReg <= 8'h00;
			byteBit  <= 3'd0;
			bitCnt   <= 2'd0;
			tripTrue <= 1'b0;
			tripCmp  <= 1'b0;
			dirBit   <= 1'b0;
		end else if (takeCmd) begin
			shiftReg <= (cmdOp == SWM_OP_WRITE) ? cmdData : 8'hFF;
			byteBit  <= 3'd0;
			bitCnt   <= 2'd0;
		end else if (state == SWM_ST_NEXT) begin
			shiftReg <= {sample, shiftReg[7:1]};                                          // see R1
			byteBit  <= byteBit + 3'd1;
			bitCnt   <= bitCnt + 2'd1;
			if (bitCnt == 2'd0) tripTrue <= sample;
			if (bitCnt == 2'd1) begin
				tripCmp <= sample;
				dirBit  <= chooseDir;                                                     // see R21
			end
		end
	end

	// Speed and link state follow the reset and the overdrive command.
	always_ff @(posedge clock) begin
		if (reset) begin
			fastSpeed  <= 1'b0;
			linkUp     <= 1'b0;
			afterReset <= 1'b0;
		end else if (takeCmd && isResetOp) begin
			linkUp <= 1'b0;                                                              // see R24
			if (cmdOp == SWM_OP_RESET_STD) fastSpeed <= 1'b0;                             // see R19
		end else if (state == SWM_ST_RHIGH && next_state == SWM_ST_PUSH) begin
			linkUp     <= presence;                                                      // see R8
			afterReset <= 1'b1;
		end else if (state == SWM_ST_NEXT && !isTrip && byteDone) begin
			afterReset <= 1'b0;
			if (op == SWM_OP_WRITE && afterReset && cmdByte == `SWM_ROM_OVERDRIVE) begin
				fastSpeed <= 1'b1;                                                       // see R19
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			pushData <= 8'h00;
		end else if (state == SWM_ST_RHIGH) begin
			pushData <= {7'h00, presence};
		end else if (state == SWM_ST_NEXT && isTrip) begin
			pushData <= {4'h0, tripTrue & tripCmp, dirBit, tripCmp, tripTrue};
		end else if (state == SWM_ST_NEXT) begin
			pushData <= {sample, shiftReg[7:1]};                                          // see R20
		end
	end

	swm_fifo #(
		.WIDTH (`SWM_RSP_WIDTH),
		.DEPTH (`SWM_RSP_DEPTH)
	) u_rsp_fifo (
		.clock    (clock),
		.reset    (reset),
		.inValid  (state == SWM_ST_PUSH),
		.inReady  (fifoInReady),
		.inData   (pushData),
		.outValid (rspValid),
		.outReady (rspReady),
		.outData  (rspData)
	);

	pull_low_only_a: assert property (@(posedge clock) disable iff (reset)
		lineOe |-> (lineOut == 1'b0))  // see R4
		else $error("Line driven high");

	powerup_quiet_a: assert property (@(posedge clock) disable iff (reset)
		(state == SWM_ST_PWRUP) |-> !lineOe && !cmdReady)  // see R2
		else $error("Bus touched during power-up wait");

	idle_released_a: assert property (@(posedge clock) disable iff (reset)
		(state == SWM_ST_IDLE) && $past(state == SWM_ST_IDLE) |-> !lineOe)  // see R5
		else $error("Line pulled while idle");

	reset_low_len_a: assert property (@(posedge clock) disable iff (reset)
		$past(state == SWM_ST_RLOW) && (state == SWM_ST_RHIGH) |-> $past(cnt) == rLowCyc - 1'b1 && !lineOe)  // see R12
		else $error("Reset low time wrong");

	slot_min_len_a: assert property (@(posedge clock) disable iff (reset)
		$past(state == SWM_ST_SHIGH) && (state == SWM_ST_NEXT) |-> $past(cnt) >= slotCyc)  // see R11
		else $error("Slot shorter than minimum");

	slot_low_len_a: assert property (@(posedge clock) disable iff (reset)
		$fell(state == SWM_ST_SLOW) |-> $past(cnt) == ($past(slotBit) ? oneCyc : zeroCyc) - 1'b1)  // see R16
		else $error("Slot low time wrong");

	slot_needs_link_a: assert property (@(posedge clock) disable iff (reset)
		$rose(state == SWM_ST_SLOW) |-> linkUp)  // see R10
		else $error("Slot started without presence");

	lsb_first_a: assert property (@(posedge clock) disable iff (reset)
		(state == SWM_ST_NEXT) && !takeCmd |=> shiftReg == {$past(sample), $past(shiftReg[7:1])})  // see R1
		else $error("Bit order not lsb first");

	refuse_no_slot_a: assert property (@(posedge clock) disable iff (reset)
		refuse |=> (state == SWM_ST_IDLE) && !lineOe)  // see R24
		else $error("Refused command reached the line");

	link_cleared_a: assert property (@(posedge clock) disable iff (reset)
		$rose(state == SWM_ST_RLOW) |-> !linkUp)  // see R24
		else $error("Link kept across a reset");

	read_after_release_a: assert property (@(posedge clock) disable iff (reset)
		(state == SWM_ST_SHIGH) && (cnt == rdSmpCyc - oneCyc) |-> $past(state == SWM_ST_SHIGH) && !lineOe)  // see R18
		else $error("Read sampled while line pulled");

	overdrive_cmd_a: assert property (@(posedge clock) disable iff (reset)
		$rose(fastSpeed) |-> $past(op == SWM_OP_WRITE && cmdByte == `SWM_ROM_OVERDRIVE))  // see R19
		else $error("Overdrive entered without its command");

endmodule // swm_master

//--- logic/swm_pkg.sv
// Types of the single-wire bus master: user command codes and engine states.
// Assumes nothing of its surroundings.
package swm_pkg;

	typedef enum logic [2:0] {
		SWM_OP_RESET     = 3'h0,
		SWM_OP_RESET_STD = 3'h1,
		SWM_OP_WRITE     = 3'h2,
		SWM_OP_READ      = 3'h3,
		SWM_OP_TRIPLET   = 3'h4
	} swm_op_t;

	typedef enum logic [3:0] {
		SWM_ST_PWRUP = 4'h0,
		SWM_ST_IDLE  = 4'h1,
		SWM_ST_RLOW  = 4'h3,
		SWM_ST_RHIGH = 4'h2,
		SWM_ST_SLOW  = 4'h6,
		SWM_ST_SHIGH = 4'h7,
		SWM_ST_NEXT  = 4'h5,
		SWM_ST_PUSH  = 4'h4
	} swm_state_t;

endpackage

//--- verification/swm_device_model.sv
// Behavioural identity slave for the single-wire bus.
// Assumes a bench that resolves the wired line with a pull-up and lends its clock for timing.
`timescale 1ns/1ps

module swm_device_model #(
	parameter logic [63:0] ROM       = 64'h5E3C_5A9D_017E_42A6, // Arbitrary identity value.
	parameter int          RST_MIN   = 2000,                    // Low cycles that make a reset.
	parameter int          LONG_RST  = 2500,                    // Reset length that restores standard speed.
	parameter int          PRES_WAIT = 100,                     // Wait before presence.
	parameter int          PRES_LOW  = 400,                     // Presence low cycles.
	parameter int          STD_SMP   = 900,                     // Write sample point, standard.
	parameter int          FAST_SMP  = 200,                     // Write sample point, overdrive.
	parameter int          STD_HOLD  = 1700,                    // Zero read hold, standard.
	parameter int          FAST_HOLD = 240                      // Zero read hold, overdrive.
) (
	input  wire logic clock, // Timing reference.
	input  wire logic line,  // Resolved data line.
	output logic      pull   // Pulls the line low when high.
);
	logic       fast;
	logic       active;
	logic [1:0] mode;
	logic [7:0] cmd;
	logic       drv;
	logic       rx;
	int         bitIdx;
	int         sub;
	int         n;

	task automatic step();
		case (mode)
			2'h0: begin
				cmd[bitIdx] = rx;
				bitIdx++;
				if (bitIdx == 8) begin
					bitIdx = 0;
					mode   = (cmd == 8'h33) ? 2'h1 : (cmd == 8'hF0) ? 2'h2 : 2'h3;
					fast   = fast || (cmd == 8'h3C);
				end
			end
			2'h1: bitIdx = (bitIdx + 1) % 64;
			2'h2: begin
				if (sub == 2 && rx !== ROM[bitIdx])
					mode = 2'h3;
				bitIdx = (sub == 2) ? bitIdx + 1 : bitIdx;
				sub    = (sub + 1) % 3;
			end
			default: ;
		endcase
	endtask

	initial begin
		pull   = 1'b0;
		fast   = 1'b0;
		active = 1'b0;
		mode   = 2'h3;
		forever begin
			@(negedge line);
			drv  = (mode == 2'h1 || (mode == 2'h2 && sub < 2)) ? ROM[bitIdx] ^ sub[0] : 1'b1;
			pull = active && !drv;
			n    = 0;
			// A written one releases the line before the sample point, so timing runs on to it.
			while (n < RST_MIN && (line === 1'b0 || n < (fast ? FAST_SMP : STD_SMP))) begin
				@(posedge clock);
				n++;
				if (n == (fast ? FAST_HOLD : STD_HOLD))
					pull = 1'b0;
				if (n == (fast ? FAST_SMP : STD_SMP))
					rx = line;
			end
			if (n >= RST_MIN) begin
				while (line === 1'b0) begin
					@(posedge clock);
					n++;
				end
				fast = fast && (n < LONG_RST);
				repeat (PRES_WAIT) @(posedge clock);
				pull = 1'b1;
				repeat (PRES_LOW) @(posedge clock);
				pull   = 1'b0;
				active = 1'b1;
				mode   = 2'h0;
				bitIdx = 0;
				sub    = 0;
			end else if (active) begin
				step();
			end
		end
	end
endmodule // swm_device_model

//--- verification/swm_master_tb_top.sv
// Self-checking bench of the single-wire bus master with one identity slave model.
// Assumes shortened standard timing parameters and a pull-up on the resolved line.
`timescale 1ns/1ps

module swm_master_tb_top
	import swm_pkg::*;
;
	localparam int          PWR    = 200;
	localparam int          RLOW   = 3000;
	localparam logic [63:0] ROM    = 64'h5E3C_5A9D_017E_42A6; // Arbitrary identity value.

	logic       clock;
	logic       reset;
	logic       cmdValid;
	logic       cmdReady;
	logic [2:0] cmdOp;
	logic [7:0] cmdData;
	logic       cmdRefused;
	logic       rspValid;
	logic       rspReady;
	logic [7:0] rspData;
	logic       fastSpeed;
	logic       linkUp;
	logic       busy;
	logic       lineOut;
	logic       lineOe;
	logic       devPull;
	logic       refusedSeen;
	wire        busLine;
	int         n_mismatch;
	int         tests_run;

	assign busLine = !((lineOe === 1'b1) || (devPull === 1'b1));

	swm_master #(.POWERUP_CYC(PWR), .STD_RLOW_CYC(RLOW), .STD_RHIGH_CYC(1500), .STD_PRES_CYC(300),
		.STD_SLOT_CYC(400), .STD_ZERO_CYC(1000)) i_dut (
		.clock(clock), .reset(reset), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOp(cmdOp),
		.cmdData(cmdData), .cmdRefused(cmdRefused), .rspValid(rspValid), .rspReady(rspReady),
		.rspData(rspData), .fastSpeed(fastSpeed), .linkUp(linkUp), .busy(busy), .lineIn(busLine),
		.lineOut(lineOut), .lineOe(lineOe));

	swm_device_model #(.ROM(ROM)) i_dev (.clock(clock), .line(busLine), .pull(devPull));

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wrap_up();
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Entered at a rising edge with the engine idle; leaves at the edge that takes the command.
	task automatic issue(input swm_op_t op, input logic [7:0] d);
		cmdOp    <= op;
		cmdData  <= d;
		cmdValid <= 1'b1;
		@(negedge clock);
		refusedSeen = cmdRefused;
		@(posedge clock);
		cmdValid <= 1'b0;
	endtask

	task automatic waitIdle();
		int w;
		w = 0;
		@(negedge clock);
		while (cmdReady !== 1'b1 && w < 60000) begin
			@(negedge clock);
			w++;
		end
		check("engine idle", 16'h0001, {15'h0, cmdReady});
		@(posedge clock);
	endtask

	task automatic getRsp(input string what, input logic [7:0] exp);
		@(negedge clock);
		check(what, {7'h0, 1'b1, exp}, {7'h0, rspValid, rspData});
		@(posedge clock);
		rspReady <= 1'b1;
		@(posedge clock);
		rspReady <= 1'b0;
	endtask

	task automatic tPowerUp();
		int n;
		n = 0;
		@(negedge clock);
		check("power-up busy, drive level", 16'h0010, {11'h0, busy, 3'h0, lineOut});
		while (cmdReady !== 1'b1 && n < 1000) begin
			@(negedge clock);
			n++;
		end
		check("power-up cycles", 16'(PWR), 16'(n));
		@(posedge clock);
	endtask

	task automatic tRefuse();
		int k;
		issue(SWM_OP_WRITE, 8'h33);
		check("refused flag", 16'h0001, {15'h0, refusedSeen});
		k = 0;
		repeat (40) begin
			@(negedge clock);
			k += int'(lineOe !== 1'b0);
		end
		check("line quiet", 16'h0000, 16'(k));
		waitIdle();
	endtask

	task automatic tReset(input swm_op_t op);
		int k;
		issue(op, 8'h00);
		k = 0;
		while (lineOe !== 1'b1 && k < 8) begin
			@(negedge clock);
			k++;
		end
		k = 0;
		while (lineOe === 1'b1 && k < 20000) begin
			@(negedge clock);
			k++;
		end
		check("reset low cycles", 16'(RLOW), 16'(k));
		waitIdle();
		getRsp("presence", 8'h01);
		check("link, speed", 16'h0010, {11'h0, linkUp, 3'h0, fastSpeed});
	endtask

	task automatic tReadRom();
		issue(SWM_OP_WRITE, 8'h33);
		waitIdle();
		issue(SWM_OP_READ, 8'h00);
		waitIdle();
		getRsp("family code", ROM[7:0]);
	endtask

	// Direction bit 1 is offered while the read bits differ, so the true bit must be written.
	task automatic tSearch();
		issue(SWM_OP_WRITE, 8'hF0);
		waitIdle();
		issue(SWM_OP_TRIPLET, 8'h01);
		waitIdle();
		getRsp("triplet", {5'h0, ROM[0], !ROM[0], ROM[0]});
	endtask

	task automatic tSpeed();
		issue(SWM_OP_WRITE, 8'h3C);
		waitIdle();
		check("overdrive on", 16'h0001, {15'h0, fastSpeed});
		tReset(SWM_OP_RESET_STD);
	endtask

	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	initial begin
		#900000;
		n_mismatch++;
		wrap_up();
	end

	initial begin
		reset      = 1'b1;
		cmdValid   = 1'b0;
		cmdOp      = 3'h0;
		cmdData    = 8'h00;
		rspReady   = 1'b0;
		n_mismatch = 0;
		tests_run  = 0;
		repeat (3) @(posedge clock);
		reset <= 1'b0;
		tPowerUp();
		tRefuse();
		tReset(SWM_OP_RESET);
		tReadRom();
		tReset(SWM_OP_RESET);
		tSearch();
		tReset(SWM_OP_RESET);
		tSpeed();
		wrap_up();
	end
endmodule // swm_master_tb_top
